// ### shared/bsts_pkg.sv
// Constants and types for the bit set and test-skip execution block
// Summary of operation
// RQ1: A bit-set word (opcode 0101, 3-bit bit index, 5-bit file address) forces that file bit to one.
// RQ2: A test-skip-if-clear word (opcode 0110) reads the file bit and skips the next word when it is zero.
// RQ3: A test-skip-if-set word (opcode 0111) reads the file bit and skips the next word when it is one.
// RQ4: A taken skip discards the prefetched word and runs a no-operation slot, so the test takes 2 cycles.
// RQ5: The next sequential word is fetched while the current bit instruction executes.
// RQ6: None of the three alters a status flag; each is one word and one cycle when no skip is taken.
package bsts_pkg;
    localparam int INSTR_W = 12;
    localparam int FADDR_W = 5;
    localparam int BIDX_W = 3;
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam int OPC_MSB = 11;
    localparam int OPC_LSB = 8;
    localparam int BIDX_MSB = 7;
    localparam int BIDX_LSB = 5;
    localparam int FADDR_MSB = 4;
    localparam int FADDR_LSB = 0;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_CLR = 4'h6;
    localparam logic [3:0] OPC_SKIP_SET = 4'h7;
    localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [PC_W-1:0] PC_STEP = 10'h001;

    typedef enum logic [3:0] {
        BSTS_OP_NONE = 4'b0001,
        BSTS_OP_SET = 4'b0010,
        BSTS_OP_SKC = 4'b0100,
        BSTS_OP_SKS = 4'b1000
    } bsts_op_t;

    typedef enum logic [1:0] {
        BSTS_ST_RUN = 2'b01,
        BSTS_ST_NOP = 2'b10
    } bsts_state_t;
endpackage : bsts_pkg

// ### rtl/bsts_decode.sv
// Combinational decoder of one instruction word into bit operation fields
`timescale 1ns/1ps
`default_nettype none
module bsts_decode
    import bsts_pkg::*;
(
    // Instruction word
    input wire logic [INSTR_W-1:0] instr,
    // Decoded fields
    output bsts_op_t op,
    output logic [BIDX_W-1:0] bit_idx,
    output logic [FADDR_W-1:0] file_addr
);
    always_comb
    begin
        bit_idx = instr[BIDX_MSB:BIDX_LSB];
        file_addr = instr[FADDR_MSB:FADDR_LSB];
        case (instr[OPC_MSB:OPC_LSB])
            OPC_BIT_SET: op = BSTS_OP_SET;
            OPC_SKIP_CLR: op = BSTS_OP_SKC;
            OPC_SKIP_SET: op = BSTS_OP_SKS;
            default: op = BSTS_OP_NONE;
        endcase
    end
endmodule : bsts_decode
`default_nettype wire

// ### rtl/bsts_exec.sv
// Fetch pipeline slot and executor for bit set and bit test-skip words
`timescale 1ns/1ps
`default_nettype none
module bsts_exec
    import bsts_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Program memory fetch
    output logic [PC_W-1:0] fetch_addr,
    input wire logic [INSTR_W-1:0] fetch_data,
    // File register read port (combinational)
    output logic [FADDR_W-1:0] file_raddr,
    input wire logic [DATA_W-1:0] file_rdata,
    // File register write port
    output logic file_we,
    output logic [FADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    // Execution status
    output logic [INSTR_W-1:0] exec_instr,
    output logic nop_slot,
    output logic skip_taken,
    output logic status_we
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        bsts_state_t st;
        logic [PC_W-1:0] pc;
        logic [INSTR_W-1:0] ir;
        logic ir_valid;
        logic [FADDR_W-1:0] raddr;
        logic we;
        logic [FADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [INSTR_W-1:0] xinstr;
        logic no_operation_slot;
        logic skip;
        logic flag_we;
    } bsts_regs_t;

    bsts_regs_t cur_ff;
    bsts_regs_t nxt_ff;

    bsts_op_t op;
    logic [BIDX_W-1:0] bit_idx;
    logic [FADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] set_data;
    logic test_bit;
    logic skip_want;

    // ****************************************
    // Decode of the word in the execute slot
    // ****************************************
    bsts_decode u_decode (
        .instr(cur_ff.ir),
        .op(op),
        .bit_idx(bit_idx),
        .file_addr(file_addr)
    );

    assign test_bit = file_rdata[bit_idx];

    // ****************************************
    // Bit-set data, one lane per data bit
    // ****************************************
    generate
        for (genvar lane = 0; lane < DATA_W; lane++)
        begin : g_set_lane
            // Only the addressed lane is forced high, the rest pass through
            assign set_data[lane] = file_rdata[lane] | (bit_idx == BIDX_W'(lane));
        end
    endgenerate

    // ****************************************
    // Skip decision for the two test words
    // ****************************************
    always_comb
    begin
        skip_want = 1'b0;
        case (op)
            // RQ2: skip when bit clear
            BSTS_OP_SKC:
            begin
                skip_want = ~test_bit;
            end
            // RQ3: skip when bit set
            BSTS_OP_SKS:
            begin
                skip_want = test_bit;
            end
            default:
            begin
                skip_want = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_ff = cur_ff;
        // RQ5: prefetch next word
        nxt_ff.pc = cur_ff.pc + PC_STEP;
        nxt_ff.ir = fetch_data;
        nxt_ff.ir_valid = 1'b1;
        nxt_ff.raddr = fetch_data[FADDR_MSB:FADDR_LSB];
        nxt_ff.we = 1'b0;
        nxt_ff.waddr = file_addr;
        nxt_ff.wdata = file_rdata;
        nxt_ff.xinstr = cur_ff.ir;
        nxt_ff.no_operation_slot = 1'b0;
        nxt_ff.skip = 1'b0;
        // RQ6: bit words never write flags
        nxt_ff.flag_we = 1'b0;
        nxt_ff.st = BSTS_ST_RUN;
        case (cur_ff.st)
            BSTS_ST_RUN:
            begin
                if (cur_ff.ir_valid)
                begin
                    case (op)
                        // RQ1: force bit to one
                        BSTS_OP_SET:
                        begin
                            nxt_ff.we = 1'b1;
                            // Read data of this cycle; back-to-back writes rely on
                            // the file forwarding its pending write to the read port
                            nxt_ff.wdata = set_data;
                        end
                        // RQ2: skip when bit clear
                        BSTS_OP_SKC:
                        begin
                            if (skip_want)
                            begin
                                nxt_ff.st = BSTS_ST_NOP;
                                nxt_ff.skip = 1'b1;
                            end
                        end
                        // RQ3: skip when bit set
                        BSTS_OP_SKS:
                        begin
                            if (skip_want)
                            begin
                                nxt_ff.st = BSTS_ST_NOP;
                                nxt_ff.skip = 1'b1;
                            end
                        end
                        default:
                        begin
                            nxt_ff.we = 1'b0;
                        end
                    endcase
                end
            end
            BSTS_ST_NOP:
            begin
                // RQ4: discard prefetched word
                nxt_ff.xinstr = NOP_WORD;
                nxt_ff.no_operation_slot = 1'b1;
            end
            default:
            begin
                nxt_ff.st = BSTS_ST_RUN;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_ff.st <= BSTS_ST_RUN;
            cur_ff.pc <= PC_RESET;
            cur_ff.ir <= NOP_WORD;
            cur_ff.ir_valid <= 1'b0;
            cur_ff.raddr <= '0;
            cur_ff.we <= 1'b0;
            cur_ff.waddr <= '0;
            cur_ff.wdata <= '0;
            cur_ff.xinstr <= NOP_WORD;
            cur_ff.no_operation_slot <= 1'b0;
            cur_ff.skip <= 1'b0;
            cur_ff.flag_we <= 1'b0;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign fetch_addr = cur_ff.pc;
    assign file_raddr = cur_ff.raddr;
    assign file_we = cur_ff.we;
    assign file_waddr = cur_ff.waddr;
    assign file_wdata = cur_ff.wdata;
    assign exec_instr = cur_ff.xinstr;
    assign nop_slot = cur_ff.no_operation_slot;
    assign skip_taken = cur_ff.skip;

    // ****************************************
    // Status flags
    // ****************************************
    // RQ6: status flags untouched
    assign status_we = cur_ff.flag_we;
endmodule : bsts_exec
`default_nettype wire

// ### verif/bsts_props.sv
// Checker for the bit set and test-skip executor
`timescale 1ns/1ps
`default_nettype none
module bsts_props
    import bsts_pkg::*;
(
    input wire logic sys_clk, rst_b, file_we, nop_slot, skip_taken, status_we,
    input wire logic [PC_W-1:0] fetch_addr,
    input wire logic [FADDR_W-1:0] file_raddr, file_waddr,
    input wire logic [DATA_W-1:0] file_rdata, file_wdata,
    input wire logic [INSTR_W-1:0] exec_instr
);
    logic [DATA_W-1:0] rd_ff;
    logic [3:0] opc;
    logic [2:0] bi;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    assign opc = exec_instr[11:8];
    assign bi = exec_instr[7:5];
    always_ff @(posedge sys_clk) rd_ff <= file_rdata;
    a_fetch_step: assert property ($past(rst_b) |-> fetch_addr == PC_W'($past(fetch_addr) + 1))
        else $error("fetch step");
    a_no_flags: assert property (!status_we) else $error("flag write");
    a_skip_nop: assert property (skip_taken |=> nop_slot && exec_instr == 0)
        else $error("no nop slot");
    a_nop_quiet: assert property (nop_slot |-> $past(skip_taken) && !file_we && !skip_taken)
        else $error("bad nop slot");
    a_set_write: assert property (file_we == (opc == OPC_BIT_SET))
        else $error("bad write");
    a_set_data: assert property (file_we |-> file_waddr == exec_instr[4:0]
        && file_wdata == (rd_ff | 8'h01 << bi)) else $error("bad set data");
    a_skip_set: assert property (opc == OPC_SKIP_SET |-> skip_taken == rd_ff[bi]
        && $past(file_raddr) == exec_instr[4:0]) else $error("bad skip");
    a_skip_clr: assert property (opc == OPC_SKIP_CLR |-> skip_taken == !rd_ff[bi])
        else $error("bad skip");
endmodule : bsts_props
bind bsts_exec bsts_props bsts_props_i (.*);
`default_nettype wire

// ### verif/tb_bsts_exec.sv
// Self-checking bench for the bit set and test-skip executor
`timescale 1ns/1ps
`default_nettype none
module tb_bsts_exec;
    import bsts_pkg::*;
    logic sys_clk, rst_b, file_we, nop_slot, skip_taken, status_we;
    logic [PC_W-1:0] fetch_addr;
    logic [INSTR_W-1:0] fetch_data, exec_instr, w0, w1;
    logic [FADDR_W-1:0] file_raddr, file_waddr;
    logic [DATA_W-1:0] file_rdata, file_wdata;
    logic [DATA_W-1:0] regs [0:31];
    int mismatches, check_count;
    int skip_cnt, nop_cnt, flag_cnt;
    bsts_exec bsts_exec_i (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .fetch_addr(fetch_addr),
        .fetch_data(fetch_data),
        .file_raddr(file_raddr),
        .file_rdata(file_rdata),
        .file_we(file_we),
        .file_waddr(file_waddr),
        .file_wdata(file_wdata),
        .exec_instr(exec_instr),
        .nop_slot(nop_slot),
        .skip_taken(skip_taken),
        .status_we(status_we)
    );
    // Pulse counters sampled mid-cycle where outputs are settled
    always @(negedge sys_clk)
        if (!rst_b)
        begin
            skip_cnt <= 0;
            nop_cnt <= 0;
            flag_cnt <= 0;
        end
        else
        begin
            skip_cnt <= skip_cnt + (skip_taken === 1'b1);
            nop_cnt <= nop_cnt + (nop_slot === 1'b1);
            flag_cnt <= flag_cnt + (status_we !== 1'b0);
        end
    assign fetch_data = fetch_addr == 0 ? w0 : fetch_addr == 1 ? w1 : NOP_WORD;
    // Same-cycle write is forwarded to the read
    assign file_rdata = file_we && file_waddr == file_raddr ? file_wdata : regs[file_raddr];
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        if (file_we === 1'b1)
            regs[file_waddr] <= file_wdata;
    task automatic check(input logic [DATA_W-1:0] seen, want);
        check_count++;
        if (seen !== want)
        begin
            mismatches++;
            $display("ERROR %0t: got %h exp %h", $time, seen, want);
        end
    endtask : check
    task automatic give_verdict;
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic run_prog(input logic [INSTR_W-1:0] a, b, input logic [DATA_W-1:0] f);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        w0 <= a;
        w1 <= b;
        foreach (regs[i])
            regs[i] = 8'h00;
        regs[3] = f;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (20)
            if (fetch_addr !== 10'h00a)
                @(posedge sys_clk);
        check(fetch_addr[7:0], 8'h0a);
        if (mismatches > 0)
            give_verdict();
    endtask : run_prog
    task automatic s_bit_set;
        run_prog(12'h5e3, 12'h503, 8'h0a);
        check(regs[3], 8'h8b);
        check(skip_cnt[7:0], 8'h00);
        check(flag_cnt[7:0], 8'h00);
    endtask : s_bit_set
    task automatic s_test(input logic [INSTR_W-1:0] a, input logic [DATA_W-1:0] f, input logic sk);
        // Prefetched set of file 31 bit 7 must vanish when skipped
        run_prog(a, 12'h5ff, f);
        check(regs[31], sk ? 8'h00 : 8'h80);
        check(skip_cnt[7:0], {7'h00, sk});
        check(nop_cnt[7:0], {7'h00, sk});
        check(flag_cnt[7:0], 8'h00);
    endtask : s_test
    initial
    begin
        rst_b = 1'b0;
        w0 = NOP_WORD;
        w1 = NOP_WORD;
        mismatches = 0;
        check_count = 0;
        s_bit_set();
        s_test(12'h7e3, 8'h80, 1'b1);
        s_test(12'h7e3, 8'h7f, 1'b0);
        s_test(12'h6e3, 8'h7f, 1'b1);
        s_test(12'h6e3, 8'h80, 1'b0);
        give_verdict();
    end
endmodule : tb_bsts_exec
`default_nettype wire
